// ### tfs_cmp.sv
// tfs_cmp: unsigned word compare for the two search operations
// assumes both operands are plain 16-bit words
`timescale 1ns/100ps
module tfs_cmp
  import tfs_pkg::*;
(
  input  wire logic [TFS_WORD_W-1:0] i_word,
  input  wire logic [TFS_WORD_W-1:0] i_operand,
  input  wire logic                  i_greater,
  output logic                       o_hit
);
  always_comb begin
    if (i_greater) begin
      o_hit = (i_word > i_operand);
    end else begin
      o_hit = (i_word == i_operand);
    end
  end
endmodule

// ### tfs_engine.sv
// tfs_engine: table fill, match search and greater search engine
// assumes the program loads accumulator and stack before each start pulse
`timescale 1ns/100ps
module tfs_engine
  import tfs_pkg::*;
#(
  parameter int MEM_DEPTH = 4096,
  parameter int MEM_AW    = 12
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_start,
  input  wire logic [1:0]            i_op,
  input  wire logic                  i_src_sel,
  input  wire logic [TFS_WORD_W-1:0] i_const,
  input  wire logic [TFS_ADDR_W-1:0] i_src_addr,
  input  wire logic [TFS_ACC_W-1:0]  i_acc,
  input  wire logic [TFS_ACC_W-1:0]  i_stack1,
  input  wire logic [TFS_ACC_W-1:0]  i_stack2,
  input  wire logic                  i_ext_we,
  input  wire logic [TFS_ADDR_W-1:0] i_ext_addr,
  input  wire logic [TFS_WORD_W-1:0] i_ext_wdata,
  output logic                       o_busy,
  output logic                       o_done,
  output logic      [TFS_ACC_W-1:0]  o_acc,
  output logic                       o_acc_we,
  output logic                       o_range_error_flag,
  output logic      [TFS_WORD_W-1:0] o_rdata
);
  tfs_state_e            state_reg, state_next;
  logic [1:0]            op_reg, op_next;
  logic [TFS_ADDR_W-1:0] base_reg, base_next;
  logic [TFS_LEN_W-1:0]  len_reg, len_next;
  logic [TFS_LEN_W:0]    idx_reg, idx_next;
  logic [TFS_WORD_W-1:0] opnd_reg, opnd_next;
  logic [TFS_ACC_W-1:0]  acc_reg, acc_next;
  logic                  flag_reg, flag_next;
  logic                  done_reg, done_next;
  logic                  accwe_reg, accwe_next;
  logic                  fetch_src_reg, fetch_src_next;
  logic [TFS_ADDR_W:0]   cur_addr;
  logic                  cur_ok;
  logic                  hit;
  logic                  eng_we;
  logic [MEM_AW-1:0]     raddr;
  logic [TFS_WORD_W-1:0] rdata;
  logic                  take;
  logic                  off_bad;
  logic [TFS_ADDR_W-1:0] start_base;
  logic [TFS_LEN_W-1:0]  start_len;
  logic [TFS_LEN_W:0]    start_idx;
  logic                  is_fill;
  logic                  is_match;
  logic                  is_greater;
  logic                  walk_end;

  // word address currently touched by the walk
  assign cur_addr = {1'b0, base_reg} + {{(TFS_ADDR_W-TFS_LEN_W){1'b0}},
                    idx_reg};
  assign cur_ok   = (cur_addr < {1'b0, TFS_MEM_WORDS});

  assign is_fill    = (op_reg == TFS_OP_FILL);
  assign is_match   = (op_reg == TFS_OP_MATCH);
  // the spare code 3 searches as greater
  assign is_greater = op_reg[1];
  assign walk_end   = (idx_reg >= {1'b0, len_reg});

  tfs_cmp i_tfs_cmp (
    .i_word    (rdata),
    .i_operand (opnd_reg),
    .i_greater (is_greater),
    .o_hit     (hit)
  );

  // memory write from the fill walk, else from outside
  logic [MEM_AW-1:0]     waddr;
  logic [TFS_WORD_W-1:0] wdata;
  logic                  mem_we;
  always_comb begin
    eng_we = (state_reg == TFS_WALK) && (op_reg == TFS_OP_FILL) &&
             cur_ok && (idx_reg < {1'b0, len_reg});
    mem_we = eng_we || i_ext_we;
    waddr  = eng_we ? cur_addr[MEM_AW-1:0] : i_ext_addr[MEM_AW-1:0];
    wdata  = eng_we ? opnd_reg : i_ext_wdata;
  end

  always_comb begin
    if (state_reg == TFS_IDLE && i_src_sel == TFS_SRC_MEM) begin
      raddr = i_src_addr[MEM_AW-1:0];
    end else if (state_reg == TFS_IDLE) begin
      raddr = i_ext_addr[MEM_AW-1:0];
    end else begin
      raddr = cur_addr[MEM_AW-1:0];
    end
  end

  tfs_word_mem #(
    .DEPTH (MEM_DEPTH),
    .AW    (MEM_AW)
  ) i_tfs_word_mem (
    .i_clk   (i_clk),
    .i_we    (mem_we),
    .i_waddr (waddr),
    .i_wdata (wdata),
    .i_raddr (raddr),
    .o_rdata (rdata)
  );

  // operation parameters as the program left them for this scan
  always_comb begin
    take    = i_start && (state_reg == TFS_IDLE);
    off_bad = 1'b0;
    if (i_op == TFS_OP_MATCH) begin
      start_base = i_stack1[TFS_ADDR_W-1:0];
      start_len  = i_stack2[TFS_LEN_W-1:0];
      off_bad    = (i_acc[15:0] > {8'h00, i_stack2[TFS_LEN_W-1:0]});
      start_idx  = off_bad ? '1 : i_acc[TFS_LEN_W:0];
    end else begin
      start_base = i_acc[TFS_ADDR_W-1:0];
      start_len  = i_stack1[TFS_LEN_W-1:0];
      start_idx  = '0;
    end
  end

  // control group: sequence, operation and table bounds
  always_comb begin
    state_next     = state_reg;
    op_next        = op_reg;
    base_next      = base_reg;
    len_next       = len_reg;
    fetch_src_next = fetch_src_reg;
    unique case (state_reg)
      TFS_IDLE: begin
        // nothing changes unless the rung enables this scan
        if (take) begin
          op_next        = i_op;
          base_next      = start_base;
          len_next       = start_len;
          fetch_src_next = (i_src_sel == TFS_SRC_MEM);
          state_next     = TFS_FETCH;
        end
      end
      TFS_FETCH: begin
        if (is_match && walk_end) begin
          state_next = TFS_DONE;
        end else begin
          state_next = is_fill ? TFS_WALK : TFS_WAIT;
        end
      end
      TFS_WAIT: begin
        // memory read is registered; one cycle before compare
        state_next = TFS_WALK;
      end
      TFS_WALK: begin
        if (walk_end || (!is_fill && hit)) begin
          state_next = TFS_DONE;
        end else if (!is_fill) begin
          state_next = TFS_WAIT;
        end
      end
      TFS_DONE: begin
        state_next = TFS_IDLE;
      end
      default: begin
        state_next = TFS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg     <= TFS_IDLE;
      op_reg        <= TFS_OP_FILL;
      base_reg      <= '0;
      len_reg       <= '0;
      fetch_src_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      op_reg        <= op_next;
      base_reg      <= base_next;
      len_reg       <= len_next;
      fetch_src_reg <= fetch_src_next;
    end
  end

  // index group: offset of the word the walk is on
  always_comb begin
    idx_next = idx_reg;
    if (take) begin
      idx_next = start_idx;
    end else if (state_reg == TFS_WALK && !walk_end &&
                 (is_fill || !hit)) begin
      idx_next = idx_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idx_reg <= '0;
    end else begin
      idx_reg <= idx_next;
    end
  end

  // operand group: constant at start, memory word one cycle later
  always_comb begin
    opnd_next = opnd_reg;
    if (take) begin
      opnd_next = i_const;
    end else if (state_reg == TFS_FETCH && fetch_src_reg) begin
      opnd_next = rdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      opnd_reg <= '0;
    end else begin
      opnd_reg <= opnd_next;
    end
  end

  // result group: accumulator, range flag and completion pulses
  always_comb begin
    acc_next   = acc_reg;
    flag_next  = flag_reg;
    done_next  = 1'b0;
    accwe_next = 1'b0;
    unique case (state_reg)
      TFS_IDLE: begin
        if (take) begin
          flag_next = 1'b0;
        end
      end
      TFS_FETCH: begin
        if (is_match && walk_end) begin
          flag_next = 1'b1;
          acc_next  = TFS_ACC_RST;
        end
      end
      TFS_WAIT: begin
        done_next = 1'b0;
      end
      TFS_WALK: begin
        if (walk_end) begin
          if (!is_fill) begin
            flag_next = 1'b1;
            acc_next  = TFS_ACC_RST;
          end
        end else if (is_fill) begin
          if (!cur_ok) begin
            flag_next = 1'b1;
          end
        end else if (hit) begin
          acc_next = {{(TFS_ACC_W-TFS_LEN_W-1){1'b0}}, idx_reg};
        end
      end
      TFS_DONE: begin
        done_next  = 1'b1;
        accwe_next = !is_fill;
      end
      default: begin
        done_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_reg   <= TFS_ACC_RST;
      flag_reg  <= TFS_FLAG_RST;
      done_reg  <= 1'b0;
      accwe_reg <= 1'b0;
    end else begin
      acc_reg   <= acc_next;
      flag_reg  <= flag_next;
      done_reg  <= done_next;
      accwe_reg <= accwe_next;
    end
  end

  assign o_busy             = (state_reg != TFS_IDLE);
  assign o_done             = done_reg;
  assign o_acc_we           = accwe_reg;
  assign o_acc              = acc_reg;
  assign o_range_error_flag = flag_reg;
  assign o_rdata            = rdata;
endmodule

// ### tfs_engine_chk.sv
// tfs_engine_chk: handshake and result checks on the engine ports
// assumes a bind onto tfs_engine; one clock, async active-low reset
`timescale 1ns/100ps
module tfs_engine_chk (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_start,
  input wire logic        o_busy,
  input wire logic        o_done,
  input wire logic [31:0] o_acc,
  input wire logic        o_acc_we,
  input wire logic        o_range_error_flag
);
  logic take;
  assign take = i_start && !o_busy;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  take_busy_a: assert property (take |=> o_busy)
    else $error("start not taken");
  done_time_a: assert property (take |-> ##[1:600] o_done)
    else $error("no done after start");
  done_pulse_a: assert property (o_done |=> !o_done)
    else $error("done held too long");
  we_done_a: assert property (o_acc_we |-> o_done)
    else $error("acc write without done");
  flag_clear_a: assert property (take |=> !o_range_error_flag)
    else $error("flag not overwritten at start");
  flag_hold_a: assert property (
    !take && !o_busy |=> $stable(o_range_error_flag))
    else $error("flag moved while idle");
  acc_hold_a: assert property (!take && !o_busy |=> $stable(o_acc))
    else $error("acc moved while idle");
  err_zero_a: assert property (
    o_acc_we && o_range_error_flag |-> o_acc == 32'h0)
    else $error("error result not zero");
  off_width_a: assert property (o_acc_we |-> o_acc[31:8] == 24'h0)
    else $error("offset wider than a table");
endmodule

// ### tfs_engine_test.sv
// tfs_engine_test: directed scenarios for fill, match and greater search
// assumes tfs_pkg, tfs_engine and its parts, model and checker compiled
`timescale 1ns/100ps
module tfs_engine_test;
  import tfs_pkg::*;
  logic        clk = 0, rst_n = 0, start = 0, sel = 0, ewe = 0, ld = 0;
  logic [1:0]  op = 0;
  logic [15:0] cst = 0, saddr = 0, eaddr = 0, ewd = 0, rdata;
  logic [31:0] ldv = 0, acc, s1, s2, oacc;
  logic        busy, done, acc_we, flag, got_we;
  int          fails = 0, n_checks = 0;
  always #5 clk = ~clk;
  tfs_prog_model i_tfs_prog_model (.i_clk(clk), .i_rst_n(rst_n),
    .i_load(ld), .i_value(ldv), .o_acc(acc), .o_stack1(s1), .o_stack2(s2));
  tfs_engine i_tfs_engine (.i_clk(clk), .i_rst_n(rst_n), .i_start(start),
    .i_op(op), .i_src_sel(sel), .i_const(cst), .i_src_addr(saddr),
    .i_acc(acc), .i_stack1(s1), .i_stack2(s2), .i_ext_we(ewe),
    .i_ext_addr(eaddr), .i_ext_wdata(ewd), .o_busy(busy), .o_done(done),
    .o_acc(oacc), .o_acc_we(acc_we), .o_range_error_flag(flag),
    .o_rdata(rdata));
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic load(input logic [31:0] v);
    @(negedge clk) {ld, ldv} = {1'b1, v};
    @(negedge clk) ld = 0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk) {ewe, eaddr, ewd} = {1'b1, a, d};
    @(negedge clk) ewe = 0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    @(negedge clk) {sel, eaddr} = {1'b1, a};
    @(negedge clk) chk(32'(rdata), 32'(e));
  endtask
  task automatic run(input logic [1:0] o, input logic s, input logic [15:0] c,
                     input logic [15:0] a);
    int n;
    @(negedge clk) {op, sel, cst, saddr, start} = {o, s, c, a, 1'b1};
    @(negedge clk) start = 0;
    for (n = 0; n < 700 && done !== 1'b1; n++) @(negedge clk);
    if (n == 700) begin
      fails++;
      test_done();
    end
    got_we = acc_we;
    @(negedge clk);
  endtask
  task automatic srch(input logic [1:0] o, input logic s, input logic [15:0] c,
                      input logic [15:0] a, input logic [31:0] e,
                      input logic f);
    run(o, s, c, a);
    chk(32'(got_we), 32'h1);
    chk(oacc, e);
    chk(32'(flag), 32'(f));
  endtask
  task automatic t_fill();
    wr(16'h0013, 16'h1234);
    load(32'h3);
    load(32'h10);
    run(TFS_OP_FILL, TFS_SRC_CONST, 16'habcd, 16'h0);
    chk(32'(got_we), 32'h0);
    chk(32'(flag), 32'h0);
    for (int i = 0; i < 4; i++)
      rd_chk(16'h10 + 16'(i), (i < 3) ? 16'habcd : 16'h1234);
    load(32'h4);
    load(32'h0ffe);
    run(TFS_OP_FILL, TFS_SRC_CONST, 16'h5a5a, 16'h0);
    chk(32'(flag), 32'h1);
    rd_chk(16'h0fff, 16'h5a5a);
    load(32'h2);
    load(32'h30);
    run(TFS_OP_FILL, TFS_SRC_MEM, 16'h0, 16'h0013);
    chk(32'(flag), 32'h0);
    rd_chk(16'h0031, 16'h1234);
    $display("fill test ended");
  endtask
  task automatic t_match();
    logic [15:0] tbl [4] = '{16'h5, 16'h7, 16'h5, 16'h9};
    for (int i = 0; i < 4; i++) wr(16'h20 + 16'(i), tbl[i]);
    load(32'h4);
    load(32'h20);
    load(32'hffff_0001);
    srch(TFS_OP_MATCH, TFS_SRC_CONST, 16'h5, 0, 32'h2, 0);
    load(32'h4);
    load(32'h20);
    load(32'h5);
    srch(TFS_OP_MATCH, TFS_SRC_CONST, 16'h5, 0, 32'h0, 1);
    load(32'h4);
    load(32'h20);
    load(32'h0);
    srch(TFS_OP_MATCH, TFS_SRC_CONST, 16'h3, 0, 32'h0, 1);
    $display("match test ended");
  endtask
  task automatic t_greater();
    wr(16'h0023, 16'h8000);
    wr(16'h0040, 16'h0009);
    load(32'h4);
    load(32'h20);
    srch(TFS_OP_GREATER, TFS_SRC_MEM, 0, 16'h40, 32'h3, 0);
    srch(TFS_OP_GREATER, TFS_SRC_CONST, 16'h4, 0, 32'h0, 0);
    srch(TFS_OP_GREATER, TFS_SRC_CONST, 16'hffff, 0, 32'h0, 1);
    srch(TFS_OP_GREATER, TFS_SRC_CONST, 16'h6, 0, 32'h1, 0);
    srch(2'h3, TFS_SRC_CONST, 16'h6, 0, 32'h1, 0);
    $display("greater test ended");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk) rst_n = 1;
    t_fill();
    t_match();
    t_greater();
    test_done();
  end
endmodule
bind tfs_engine tfs_engine_chk i_tfs_engine_chk (.i_clk(i_clk),
  .i_rst_n(i_rst_n), .i_start(i_start), .o_busy(o_busy), .o_done(o_done),
  .o_acc(o_acc), .o_acc_we(o_acc_we),
  .o_range_error_flag(o_range_error_flag));

// ### tfs_pkg.sv
// tfs_pkg: shared constants for the table fill/search engine
// assumes a 16-bit word memory addressed by hexadecimal word address
package tfs_pkg;
  localparam int          TFS_WORD_W      = 16;
  localparam int          TFS_ADDR_W      = 16;
  localparam int          TFS_LEN_W       = 8;
  localparam int          TFS_ACC_W       = 32;
  localparam logic [15:0] TFS_MEM_WORDS   = 16'h1000;
  localparam logic [31:0] TFS_ACC_RST     = 32'h0000_0000;
  localparam logic        TFS_FLAG_RST    = 1'b0;
  localparam logic [1:0]  TFS_OP_FILL     = 2'h0;
  localparam logic [1:0]  TFS_OP_MATCH    = 2'h1;
  localparam logic [1:0]  TFS_OP_GREATER  = 2'h2;
  localparam logic        TFS_SRC_MEM     = 1'b0;
  localparam logic        TFS_SRC_CONST   = 1'b1;
  typedef enum logic [2:0] {
    TFS_IDLE  = 3'b000,
    TFS_FETCH = 3'b001,
    TFS_WALK  = 3'b011,
    TFS_WAIT  = 3'b010,
    TFS_DONE  = 3'b110
  } tfs_state_e;
endpackage

// ### tfs_prog_model.sv
// tfs_prog_model: user program side that loads the accumulator and stack
// assumes one load strobe a cycle, changed off the rising clock edge
`timescale 1ns/100ps
module tfs_prog_model
  import tfs_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_load,
  input  wire logic [TFS_ACC_W-1:0] i_value,
  output logic      [TFS_ACC_W-1:0] o_acc,
  output logic      [TFS_ACC_W-1:0] o_stack1,
  output logic      [TFS_ACC_W-1:0] o_stack2
);
  // each load pushes the stack down; values arrive already in hex
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_acc    <= '0;
      o_stack1 <= '0;
      o_stack2 <= '0;
    end else if (i_load) begin
      o_stack2 <= o_stack1;
      o_stack1 <= o_acc;
      o_acc    <= i_value;
    end
  end
endmodule

// ### tfs_word_mem.sv
// tfs_word_mem: word memory, one write port and one registered read port
// assumes a single clock; read data appear one cycle after the address
`timescale 1ns/100ps
module tfs_word_mem
  import tfs_pkg::*;
#(
  parameter int DEPTH = 4096,
  parameter int AW    = 12
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_we,
  input  wire logic [AW-1:0]         i_waddr,
  input  wire logic [TFS_WORD_W-1:0] i_wdata,
  input  wire logic [AW-1:0]         i_raddr,
  output logic      [TFS_WORD_W-1:0] o_rdata
);
  logic [TFS_WORD_W-1:0] mem [DEPTH];
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule
